/* rtl/owd_cfg.svh */
// constants for the one-wire activity-detect configuration link
// assumes a 100 MHz aclk on both ends and a pdm clock made by the host
`ifndef OWD_CFG_SVH
`define OWD_CFG_SVH

`define OWD_CLK_PERIOD_NS  10
`define OWD_PILOT_MIN      8'd8
`define OWD_PILOT_MAX      8'd20
`define OWD_PILOT_TYP      8'd10
`define OWD_STOP_MIN       8'd128
`define OWD_STOP_TX        8'd130
`define OWD_NBITS          5'd24
`define OWD_DEV_ADDR       7'h53
`define OWD_RW_WRITE       1'b0
`define OWD_REG_ENABLE     8'h29
`define OWD_REG_LOWPASS    8'h35
`define OWD_REG_THRESH     8'h36
`define OWD_EN_BIT         3
`define OWD_LPF_MSB        2
`define OWD_TH_MSB         3
`define OWD_EN_RST         1'b0
`define OWD_LPF_RST        3'h0
`define OWD_TH_RST         4'h0
`define OWD_UNLOCK_0       8'h5c
`define OWD_UNLOCK_1       8'h3e
`define OWD_UNLOCK_2       8'h6f
`define OWD_UNLOCK_3       8'h3b
`define OWD_UNLOCK_4       8'h4c
`define OWD_UNLOCK_DATA    8'h00
`define OWD_UNLOCK_DONE    3'h5
`define OWD_ACK_NS         12000
`define OWD_ACK_CYC        (`OWD_ACK_NS / `OWD_CLK_PERIOD_NS)
`define OWD_CLK_OFF_CYC    4000
`define OWD_HR_CMD         4'h0
`define OWD_HR_DIV         4'h4
`define OWD_HR_CLKEN       4'h8
`define OWD_HR_STATUS      4'hc
`define OWD_DIV_RST        16'h01f4
`define OWD_ST_BUSY        0
`define OWD_ST_WAKE        1
`define OWD_RESP_OKAY      2'h0
`define OWD_RESP_SLVERR    2'h2

`endif

/* rtl/owd_pkg.sv */
// types shared by both ends of the configuration link
// assumes owd_cfg.svh for all numeric constants
package owd_pkg;

    typedef enum logic [1:0] {
        OWD_RX_IDLE = 2'b00,
        OWD_RX_DATA = 2'b01,
        OWD_RX_STOP = 2'b10
    } owd_rx_e;

    typedef enum logic [2:0] {
        OWD_TX_IDLE  = 3'b000,
        OWD_TX_START = 3'b001,
        OWD_TX_PILOT = 3'b010,
        OWD_TX_GAP   = 3'b011,
        OWD_TX_BIT   = 3'b100,
        OWD_TX_STOP  = 3'b101
    } owd_tx_e;

endpackage : owd_pkg

/* rtl/owd_link_if.sv */
// pins between host and detector: pdm clock, serial config pin, wake
// assumes both ends run on the same aclk
`timescale 1ns/1ns
interface owd_link_if;
    logic pdm_clk;
    logic config_serial_pin;
    logic wake;

    modport host (output pdm_clk, output config_serial_pin, input wake);
    modport dev  (input pdm_clk, input config_serial_pin, output wake);
endinterface : owd_link_if

/* rtl/owd_device.sv */
// detector end: decodes one-wire writes, holds analog detect settings, drives wake
// assumes pdm clock and config pin synchronous to aclk
//
// Chosen here: the one-wire config pin as the only write path; the AXI4-Lite slave port is in the host.
`timescale 1ns/1ns
`include "owd_cfg.svh"
module owd_device #(
    parameter int ACK_CYCLES     = `OWD_ACK_CYC,
    parameter int CLK_OFF_CYCLES = `OWD_CLK_OFF_CYC
) (
    input  wire logic       aclk,
    input  wire logic       aresetn,
    owd_link_if.dev         link,
    input  wire logic       activity_in,
    output logic [2:0]      analog_lowpass_field,
    output logic [3:0]      analog_threshold_field,
    output logic            analog_detect_enable_bit,
    output logic            unlocked,
    output logic            write_accepted
);
    import owd_pkg::*;

    localparam int AW = $clog2(ACK_CYCLES + 1);
    localparam int IW = $clog2(CLK_OFF_CYCLES + 1);

    owd_rx_e      st_reg;
    logic         clk_q_reg;
    logic         pin_q_reg;
    logic [7:0]   run_reg;
    logic [7:0]   tp_reg;
    logic [4:0]   nbits_reg;
    logic [23:0]  shift_reg;
    logic [2:0]   unlock_reg;
    logic [AW-1:0] ack_reg;
    logic [IW-1:0] idle_reg;
    logic         wake_reg;
    logic         acc_reg;
    logic [7:0]   unlock_addr;

    ////////////////////////////////////////////////////////////////////////////
    // sampling and symbol width arithmetic
    wire       pin     = link.config_serial_pin;
    wire       rise    = link.pdm_clk & ~clk_q_reg;
    wire       chg     = rise && (pin != pin_q_reg);
    wire       hi_end  = chg && pin_q_reg;
    wire       lo_end  = chg && !pin_q_reg;
    wire [9:0] w2      = {1'b0, run_reg, 1'b0};
    wire [9:0] w1      = {2'b00, run_reg};
    wire [9:0] tp1     = {2'b00, tp_reg};
    wire [9:0] tp2     = {1'b0, tp_reg, 1'b0};
    wire [9:0] tp3     = tp1 + tp2;
    wire [9:0] tp4     = {tp_reg, 2'b00};
    wire [9:0] tp7     = tp4 + tp3;
    wire       is_zero = (run_reg != 8'h00) && (w2 <= tp3);
    wire       is_one  = (w2 >= tp4) && (w2 <= tp7);
    wire       gap_ok  = (w1 >= tp1) && (w1 <= tp2);
    wire       gap_long = rise && !pin && !pin_q_reg && (w1 >= tp2);
    wire       pilot_ok = (run_reg >= `OWD_PILOT_MIN) && (run_reg <= `OWD_PILOT_MAX);

    wire [7:0] f_dev  = shift_reg[23:16];
    wire [7:0] f_reg  = shift_reg[15:8];
    wire [7:0] f_data = shift_reg[7:0];

    // stop recognised on the 128th sampled high level after 24 bits
    wire stop_hit = (st_reg == OWD_RX_DATA) && (nbits_reg == `OWD_NBITS) && rise
                    && pin && pin_q_reg && (run_reg == `OWD_STOP_MIN - 8'd1);
    wire addr_ok  = (f_dev == {`OWD_DEV_ADDR, `OWD_RW_WRITE});
    wire commit   = stop_hit && addr_ok;
    wire unl      = (unlock_reg == `OWD_UNLOCK_DONE);
    wire wr_ok    = commit && unl;

    ////////////////////////////////////////////////////////////////////////////
    // edge history
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            clk_q_reg <= 1'b0;
            pin_q_reg <= 1'b0;
        end else begin
            clk_q_reg <= link.pdm_clk;
            if (rise) begin
                pin_q_reg <= pin;
            end
        end
    end

    // run length of the current level in pdm clock cycles
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            run_reg <= 8'h00;
        end else if (rise) begin
            if (chg) begin
                run_reg <= 8'h01;
            end else if (run_reg != 8'hff) begin
                run_reg <= run_reg + 8'h01;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // symbol decoder
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st_reg    <= OWD_RX_IDLE;
            tp_reg    <= `OWD_PILOT_TYP;
            nbits_reg <= 5'h00;
            shift_reg <= 24'h000000;
        end else begin
            unique case (st_reg)
                OWD_RX_IDLE: begin
                    if (hi_end && pilot_ok) begin
                        tp_reg    <= run_reg;
                        nbits_reg <= 5'h00;
                        st_reg    <= OWD_RX_DATA;
                    end
                end
                OWD_RX_DATA: begin
                    if (stop_hit) begin
                        st_reg <= OWD_RX_STOP;
                    end else if (gap_long) begin
                        st_reg <= OWD_RX_IDLE;
                    end else if (lo_end && !gap_ok) begin
                        st_reg <= OWD_RX_IDLE;
                    end else if (hi_end) begin
                        if (nbits_reg == `OWD_NBITS) begin
                            st_reg <= OWD_RX_IDLE;
                        end else if (is_zero || is_one) begin
                            shift_reg <= {shift_reg[22:0], is_one};
                            nbits_reg <= nbits_reg + 5'h01;
                        end else begin
                            st_reg <= OWD_RX_IDLE;
                        end
                    end
                end
                OWD_RX_STOP: begin
                    if (hi_end) begin
                        st_reg <= OWD_RX_IDLE;
                    end
                end
                default: begin
                    st_reg <= OWD_RX_IDLE;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // unlock sequence tracking
    always_comb begin
        unique case (unlock_reg)
            3'h0:    unlock_addr = `OWD_UNLOCK_0;
            3'h1:    unlock_addr = `OWD_UNLOCK_1;
            3'h2:    unlock_addr = `OWD_UNLOCK_2;
            3'h3:    unlock_addr = `OWD_UNLOCK_3;
            3'h4:    unlock_addr = `OWD_UNLOCK_4;
            default: unlock_addr = 8'h00;
        endcase
    end

    // only aresetn relocks
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            unlock_reg <= 3'h0;
        end else if (commit && !unl) begin
            if (f_reg == unlock_addr && f_data == `OWD_UNLOCK_DATA) begin
                unlock_reg <= unlock_reg + 3'h1;
            end else if (f_reg == `OWD_UNLOCK_0 && f_data == `OWD_UNLOCK_DATA) begin
                unlock_reg <= 3'h1;
            end else begin
                unlock_reg <= 3'h0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // analog detect settings
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            analog_lowpass_field <= `OWD_LPF_RST;
        end else if (wr_ok && f_reg == `OWD_REG_LOWPASS) begin
            analog_lowpass_field <= f_data[`OWD_LPF_MSB:0];
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            analog_threshold_field <= `OWD_TH_RST;
        end else if (wr_ok && f_reg == `OWD_REG_THRESH) begin
            analog_threshold_field <= f_data[`OWD_TH_MSB:0];
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            analog_detect_enable_bit <= `OWD_EN_RST;
        end else if (wr_ok && f_reg == `OWD_REG_ENABLE) begin
            analog_detect_enable_bit <= f_data[`OWD_EN_BIT];
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            unlocked <= 1'b0;
            acc_reg  <= 1'b0;
        end else begin
            unlocked <= unl;
            acc_reg  <= wr_ok;
        end
    end

    assign write_accepted = acc_reg;

    ////////////////////////////////////////////////////////////////////////////
    // acknowledge pulse on enable rising
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ack_reg <= '0;
        end else if (wr_ok && f_reg == `OWD_REG_ENABLE && f_data[`OWD_EN_BIT]
                     && !analog_detect_enable_bit) begin
            ack_reg <= AW'(ACK_CYCLES);
        end else if (ack_reg != '0) begin
            ack_reg <= ack_reg - AW'(1);
        end
    end

    // clock considered off after CLK_OFF_CYCLES without a pdm clock change
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            idle_reg <= '0;
        end else if (link.pdm_clk != clk_q_reg) begin
            idle_reg <= '0;
        end else if (idle_reg != IW'(CLK_OFF_CYCLES)) begin
            idle_reg <= idle_reg + IW'(1);
        end
    end

    wire clk_off = (idle_reg == IW'(CLK_OFF_CYCLES));

    ////////////////////////////////////////////////////////////////////////////
    // wake output
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wake_reg <= 1'b0;
        end else begin
            wake_reg <= (ack_reg != '0)
                        | (analog_detect_enable_bit & clk_off & activity_in);
        end
    end

    assign link.wake = wake_reg;

endmodule : owd_device

/* rtl/owd_host.sv */
// host end: axi4-lite slave, pdm clock divider and one-wire write serialiser
// assumes wake from the detector is synchronous to aclk
`timescale 1ns/1ns
`include "owd_cfg.svh"
module owd_host (
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic [3:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [3:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    owd_link_if.host         link
);
    import owd_pkg::*;

    logic        aw_got_reg, w_got_reg;
    logic [3:0]  awaddr_reg;
    logic [31:0] wdata_reg;
    logic [15:0] div_reg, dcnt_reg;
    logic        clken_reg, pdm_reg, pin_reg, start_reg;
    owd_tx_e     tx_reg;
    logic [7:0]  cnt_reg;
    logic [4:0]  nb_reg;
    logic [23:0] sh_reg;

    wire busy = (tx_reg != OWD_TX_IDLE) || start_reg;

    ////////////////////////////////////////////////////////////////////////////
    // axi4-lite slave
    assign s_axi_awready = !aw_got_reg && !s_axi_bvalid;
    assign s_axi_wready  = !w_got_reg && !s_axi_bvalid;
    assign s_axi_arready = !s_axi_rvalid;
    logic [3:0] s_axi_wstrb_q;
    wire do_wr  = aw_got_reg && w_got_reg && !s_axi_bvalid;
    wire wr_cmd = do_wr && awaddr_reg == `OWD_HR_CMD && (|s_axi_wstrb_q) && !busy;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_got_reg    <= 1'b0;
            w_got_reg     <= 1'b0;
            awaddr_reg    <= 4'h0;
            wdata_reg     <= 32'h00000000;
            s_axi_wstrb_q <= 4'h0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= `OWD_RESP_OKAY;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_got_reg <= 1'b1;
                awaddr_reg <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_got_reg     <= 1'b1;
                wdata_reg     <= s_axi_wdata;
                s_axi_wstrb_q <= s_axi_wstrb;
            end
            if (do_wr) begin
                aw_got_reg   <= 1'b0;
                w_got_reg    <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= (awaddr_reg == `OWD_HR_STATUS || awaddr_reg[1:0] != 2'b00
                                 || (awaddr_reg == `OWD_HR_CMD && busy))
                                ? `OWD_RESP_SLVERR : `OWD_RESP_OKAY;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            div_reg   <= `OWD_DIV_RST;
            clken_reg <= 1'b0;
        end else if (do_wr && (|s_axi_wstrb_q)) begin
            if (awaddr_reg == `OWD_HR_DIV) begin
                div_reg <= (wdata_reg[15:0] == 16'h0000) ? 16'h0001 : wdata_reg[15:0];
            end
            if (awaddr_reg == `OWD_HR_CLKEN) begin
                clken_reg <= wdata_reg[0];
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h00000000;
            s_axi_rresp  <= `OWD_RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp  <= `OWD_RESP_OKAY;
            unique case (s_axi_araddr)
                `OWD_HR_CMD:    s_axi_rdata <= {8'h00, sh_reg};
                `OWD_HR_DIV:    s_axi_rdata <= {16'h0000, div_reg};
                `OWD_HR_CLKEN:  s_axi_rdata <= {31'h0, clken_reg};
                `OWD_HR_STATUS: s_axi_rdata <= {30'h0, link.wake, busy};
                default: begin
                    s_axi_rdata <= 32'h00000000;
                    s_axi_rresp <= `OWD_RESP_SLVERR;
                end
            endcase
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // pdm clock divider, forced on while a write is under way
    wire tick = (dcnt_reg >= div_reg - 16'h0001);
    wire run  = clken_reg || busy || pdm_reg;
    wire fall = run && tick && pdm_reg;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            dcnt_reg <= 16'h0000;
            pdm_reg  <= 1'b0;
        end else if (!run) begin
            dcnt_reg <= 16'h0000;
        end else if (tick) begin
            dcnt_reg <= 16'h0000;
            pdm_reg  <= !pdm_reg;
        end else begin
            dcnt_reg <= dcnt_reg + 16'h0001;
        end
    end

    assign link.pdm_clk = pdm_reg;

    ////////////////////////////////////////////////////////////////////////////
    // serialiser, pin changes on pdm falling edges with typical widths
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            tx_reg    <= OWD_TX_IDLE;
            start_reg <= 1'b0;
            pin_reg   <= 1'b0;
            cnt_reg   <= 8'h00;
            nb_reg    <= 5'h00;
            sh_reg    <= 24'h000000;
        end else if (wr_cmd) begin
            start_reg <= 1'b1;
            sh_reg    <= {`OWD_DEV_ADDR, `OWD_RW_WRITE, wdata_reg[15:0]};
        end else if (fall) begin
            if (start_reg) begin
                start_reg <= 1'b0;
                tx_reg    <= OWD_TX_PILOT;
                pin_reg   <= 1'b1;
                cnt_reg   <= `OWD_PILOT_TYP - 8'd1;
                nb_reg    <= 5'h00;
            end else if (cnt_reg != 8'h00) begin
                cnt_reg <= cnt_reg - 8'd1;
            end else begin
                unique case (tx_reg)
                    OWD_TX_PILOT, OWD_TX_BIT: begin
                        tx_reg  <= OWD_TX_GAP;
                        pin_reg <= 1'b0;
                        cnt_reg <= `OWD_PILOT_TYP - 8'd1;
                    end
                    OWD_TX_GAP: begin
                        pin_reg <= 1'b1;
                        if (nb_reg == `OWD_NBITS) begin
                            tx_reg  <= OWD_TX_STOP;
                            cnt_reg <= `OWD_STOP_TX - 8'd1;
                        end else begin
                            tx_reg  <= OWD_TX_BIT;
                            cnt_reg <= sh_reg[23] ? 8'd3 * `OWD_PILOT_TYP - 8'd1
                                                  : `OWD_PILOT_TYP - 8'd1;
                            sh_reg  <= {sh_reg[22:0], sh_reg[23]};
                            nb_reg  <= nb_reg + 5'h01;
                        end
                    end
                    OWD_TX_STOP: begin
                        tx_reg  <= OWD_TX_IDLE;
                        pin_reg <= 1'b0;
                    end
                    default: begin
                        tx_reg  <= OWD_TX_IDLE;
                        pin_reg <= 1'b0;
                    end
                endcase
            end
        end
    end

    assign link.config_serial_pin = pin_reg;

endmodule : owd_host

/* tb/owd_link_props.sv */
// assertions on the link pins between host and detector
// assumes typical host widths and a pdm half period of a few aclk cycles
`timescale 1ns/1ns
module owd_link_props #(
    parameter int ACK_CYCLES     = 20,
    parameter int CLK_OFF_CYCLES = 50
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic pdm_clk,
    input wire logic config_serial_pin,
    input wire logic wake
);
    logic        sp_q, pdm_q, ack_q;
    logic [7:0]  hcnt, lcnt;
    logic [4:0]  nsym;
    logic [15:0] idle, wcnt;
    wire         sp   = config_serial_pin;
    wire         rise = pdm_clk & ~pdm_q;
    localparam logic [7:0] DEV = {7'b1010011, 1'b0};
    always_ff @(posedge aclk) begin
        sp_q  <= sp;
        pdm_q <= pdm_clk;
        hcnt  <= sp ? hcnt + 8'(rise) : 8'h00;
        wcnt  <= wake ? wcnt + 16'h0001 : 16'h0000;
        if (!aresetn) begin
            {lcnt, idle, nsym, ack_q} <= '0;
        end else begin
            lcnt  <= sp ? 8'h00 : lcnt + 8'(rise && lcnt != 8'hff);
            idle  <= (pdm_clk != pdm_q) ? 16'h0000 : idle + 16'(idle != 16'hffff);
            nsym  <= !(sp_q && !sp) ? nsym : (hcnt >= 8'd128) ? 5'h00 : nsym + 5'h01;
            ack_q <= wake && (ack_q || (wcnt == 16'h0000 && sp));
        end
    end
////////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    property p_pilot; $fell(sp) && nsym == 5'd0 |-> hcnt == 8'd10; endproperty
    a_pilot: assert property (p_pilot) else $error("bad pilot");
    property p_bits; $fell(sp) && nsym inside {[5'd1:5'd24]} |-> hcnt inside {8'd10, 8'd30}; endproperty
    a_bits: assert property (p_bits) else $error("bad bit");
    property p_msb; $fell(sp) && nsym inside {[5'd1:5'd8]}
        |-> hcnt == (DEV[3'(5'd8 - nsym)] ? 8'd30 : 8'd10); endproperty
    a_msb: assert property (p_msb) else $error("bad first bit");
    property p_stop; $fell(sp) && nsym == 5'd25 |-> hcnt >= 8'd128; endproperty
    a_stop: assert property (p_stop) else $error("bad stop");
    property p_gap; $rose(sp) && nsym != 5'd0 |-> lcnt == 8'd10; endproperty
    a_gap: assert property (p_gap) else $error("bad gap");
    property p_clk; sp || nsym != 5'd0 |-> idle < 16'd600; endproperty
    a_clk: assert property (p_clk) else $error("clock stalled");
    property p_ack; $fell(wake) && ack_q |-> wcnt == 16'(ACK_CYCLES); endproperty
    a_ack: assert property (p_ack) else $error("bad ack width");
    property p_det; $rose(wake) |-> sp || idle >= 16'(CLK_OFF_CYCLES - 2); endproperty
    a_det: assert property (p_det) else $error("wake with clock on");
    property p_rst; $rose(aresetn) |-> !wake && !sp && !pdm_clk; endproperty
    a_rst: assert property (p_rst) else $error("bad reset");
    c_stop: cover property ($fell(sp) && nsym == 5'd25);
    c_ack: cover property ($fell(wake) && ack_q);
    c_wake: cover property ($rose(wake) && !sp);
endmodule : owd_link_props

/* tb/one_wire_activity_detect_config_test.sv */
// bench: host and detector joined by the link, driven over axi4-lite
// assumes shortened ack and clock-off counts
`timescale 1ns/1ns
module one_wire_activity_detect_config_test;
    localparam int ACK = 20;
    localparam int OFF = 50;
    logic        aclk, aresetn, awv, wv, arv, act, awr, wr, bv, arr, rv, en, unl, acc;
    logic [3:0]  awa, ara, th;
    logic [31:0] wd, rd, s;
    logic [1:0]  br, rr;
    logic [2:0]  lpf;
    logic [7:0]  ulk [5] = '{8'h5c, 8'h3e, 8'h6f, 8'h3b, 8'h4c};
    int          miscompares, compares, nwake, w0, nacc, a0;
    owd_link_if link ();
    owd_host i_owd_host (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awa),
        .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hf),
        .s_axi_wvalid(wv), .s_axi_wready(wr), .s_axi_bresp(br), .s_axi_bvalid(bv),
        .s_axi_bready(1'b1), .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr),
        .s_axi_rdata(rd), .s_axi_rresp(rr), .s_axi_rvalid(rv), .s_axi_rready(1'b1),
        .link(link));
    owd_device #(.ACK_CYCLES(ACK), .CLK_OFF_CYCLES(OFF)) i_owd_device (.aclk(aclk),
        .aresetn(aresetn), .link(link), .activity_in(act), .analog_lowpass_field(lpf),
        .analog_threshold_field(th), .analog_detect_enable_bit(en), .unlocked(unl),
        .write_accepted(acc));
    owd_link_props #(.ACK_CYCLES(ACK), .CLK_OFF_CYCLES(OFF)) i_owd_link_props (
        .aclk(aclk), .aresetn(aresetn), .pdm_clk(link.pdm_clk),
        .config_serial_pin(link.config_serial_pin), .wake(link.wake));
////////////////////////////////////////////////////////////////////////////////
    always @(posedge aclk) nwake <= nwake + int'(link.wake === 1'b1);
    always @(posedge aclk) nacc <= nacc + int'(acc === 1'b1);
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        compares++;
        if (g !== e) begin
            miscompares++;
            $display("BAD %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    task automatic axi_wr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] e);
        logic ta, tw;
        {ta, tw} = 2'b00;
        awa <= a;
        wd  <= d;
        {awv, wv} <= 2'b11;
        do begin
            @(posedge aclk);
            ta = ta | awr;
            tw = tw | wr;
            if (ta) awv <= 1'b0;
            if (tw) wv <= 1'b0;
        end while (!(ta && tw));
        do @(posedge aclk); while (bv !== 1'b1);
        chk("bresp", {30'h0, e}, {30'h0, br});
    endtask : axi_wr
    task automatic axi_rd(input logic [3:0] a);
        ara <= a;
        arv <= 1'b1;
        do @(posedge aclk); while (arr !== 1'b1);
        arv <= 1'b0;
        do @(posedge aclk); while (rv !== 1'b1);
        s = rd;
        chk("rresp", 32'h0, {30'h0, rr});
    endtask : axi_rd
    task automatic idle_wait;
        do axi_rd(4'hc); while (s[0] !== 1'b0);
    endtask : idle_wait
    task automatic send(input logic [7:0] r, input logic [7:0] v);
        axi_wr(4'h0, {16'h0000, r, v}, 2'h0);
        idle_wait();
    endtask : send
    task automatic test_done;
        if (miscompares == 0 && compares > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : test_done
////////////////////////////////////////////////////////////////////////////////
    initial begin
        aclk = 1'b0;
        forever #5 aclk = ~aclk;
    end
    initial begin
        repeat (90000) @(posedge aclk);
        miscompares++;
        test_done();
    end
    initial begin
        aresetn = 1'b0;
        {awv, wv, arv, act, awa, ara, wd} = '0;
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        axi_wr(4'h4, 32'h2, 2'h0);
        axi_wr(4'h6, 32'h0, 2'h2);
        axi_rd(4'h4);
        chk("divider", 32'h2, s);
        send(8'h35, 8'h05);
        chk("locked lowpass", 32'h0, {29'h0, lpf});
        chk("locked accept", 32'h0, nacc);
        axi_wr(4'h0, 32'h5c00, 2'h0);
        axi_wr(4'h0, 32'h3500, 2'h2);
        idle_wait();
        send(8'h3b, 8'h00);
        foreach (ulk[i]) begin
            chk("unlocked", 32'h0, {31'h0, unl});
            send(ulk[i], 8'h00);
        end
        chk("unlocked", 32'h1, {31'h0, unl});
        a0 = nacc;
        send(8'h35, 8'hff);
        send(8'h36, 8'hff);
        chk("lowpass", 32'h7, {29'h0, lpf});
        chk("threshold", 32'hf, {28'h0, th});
        chk("accepted", 32'h2, nacc - a0);
        w0 = nwake;
        send(8'h29, 8'h08);
        chk("enable", 32'h1, {31'h0, en});
        axi_wr(4'h8, 32'h1, 2'h0);
        act <= 1'b1;
        repeat (80) @(posedge aclk);
        chk("ack width", ACK, nwake - w0);
        chk("wake clock on", 32'h0, {31'h0, link.wake});
        axi_wr(4'h8, 32'h0, 2'h0);
        repeat (80) @(posedge aclk);
        chk("wake detect", 32'h1, {31'h0, link.wake});
        act <= 1'b0;
        repeat (3) @(posedge aclk);
        chk("wake release", 32'h0, {31'h0, link.wake});
        send(8'h29, 8'h00);
        act <= 1'b1;
        repeat (80) @(posedge aclk);
        chk("wake disabled", 32'h0, {31'h0, link.wake});
        chk("unlock kept", 32'h1, {31'h0, unl});
        aresetn <= 1'b0;
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        chk("relock", 32'h0, {31'h0, unl});
        test_done();
    end
endmodule : one_wire_activity_detect_config_test
